// [logic/lane_input_consts.svh]
// Named constants for the sink lane input stage: widths, register map,
// field positions and control character codes.
// Assumes inclusion by bare name from every file that needs a figure.
//
// How it works
// - Lane inputs are 20 bits without link-rate support, 40 bits with it.
// - Character mode uses the low 20 bits; fixed-rate-link mode uses all 40 only when support is on.
// - First lane: blue channel 0 or link lane 0, on its own lane clock.
// - Second lane: green channel 1 or link lane 1, on its own lane clock.
// - Third lane: red channel 2 or link lane 2, on its own lane clock.
// - Fourth lane ignored in character mode; link lane 3 when support enabled.
// - Six control bits per slot: control bits 3..0 on top, two zero bits below.
// - Link type output: 0 for DVI, 1 for HDMI, on the lane-0 clock.
// - Four-bit equaliser level maps to bits 4 to 7 of sink register 0x31.
// - Two lowest link rates use three lanes; higher rates use all four.
`ifndef LANE_INPUT_CONSTS_SVH
`define LANE_INPUT_CONSTS_SVH

// ==========================================================
// Widths
`define LANE_W        40
`define CHAR_W        20
`define SYM_W         10
`define SLOTS         2
`define CTRL_W        12
`define NLANES        4
`define FIELD_W       6

// ==========================================================
// Register map, word addresses
`define ADDR_W        6
`define REG_CTRL      6'h00
`define REG_STATUS    6'h01
`define REG_SINKCFG   6'h31
`define CTRL_RESET    6'h00
`define CTRL_FRL      0
`define CTRL_SUPPORT  1
`define CTRL_RATE_LSB 2
`define CTRL_RATE_MSB 5
`define RATE_4LANE    4'h3
`define ST_LOCK       0
`define ST_HDMI       1
`define ST_LANE_LSB   4
`define ST_CTRL_LSB   8
`define FFE_LSB       4

// ==========================================================
// Control period characters, indexed by {C1,C0}
`define CODE_CTL00    10'h354
`define CODE_CTL01    10'h0ab
`define CODE_CTL10    10'h154
`define CODE_CTL11    10'h2ab

`endif

// [logic/lane_input_pkg.sv]
// Types shared by the sink lane input stage.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package lane_input_pkg;
  // Bus slave sequence, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } busState_t;
endpackage
`default_nettype wire

// [logic/lane_if.sv]
// Carrier for captured lane words from the top to the control decoder.
// Assumes all signals are on mclk.
`include "lane_input_consts.svh"
`default_nettype none
interface lane_if;
  logic [`NLANES-1:0][`LANE_W-1:0] word;
  logic [`NLANES-1:0]              strobe;
  logic                            charMode;
  logic                            locked;
  modport producer (output word, output strobe, output charMode, output locked);
  modport consumer (input word, input strobe, input charMode, input locked);
endinterface
`default_nettype wire

// [logic/lane_capture.sv]
// One lane: finds the edges of the lane clock and captures the lane word.
// Assumes the lane clock is much slower than mclk and data is stable
// around its rising edge.
`include "lane_input_consts.svh"
`default_nettype none
module lane_capture (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // Lane from the transceiver
  input  wire logic               laneClock,
  input  wire logic [`LANE_W-1:0] laneData,
  // Control
  input  wire logic               enable,
  input  wire logic               wideMode,
  // Captured word
  output logic                    strobe,
  output logic [`LANE_W-1:0]      word
);
  logic [2:0]         clkSync_r;
  logic               clkLevel_r;
  logic               risingEdge;
  logic [`LANE_W-1:0] masked;

  // ==========================================================
  // Edge finding
  // Three stages; stage 0 feeds only stage 1
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clkSync_r <= 3'h0;
    end else begin
      clkSync_r <= {clkSync_r[1:0], laneClock};
    end
  end

  // Level moves only once stages 1 and 2 agree
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clkLevel_r <= 1'b0;
    end else if (clkSync_r[1] == clkSync_r[2]) begin
      clkLevel_r <= clkSync_r[2];
    end
  end

  assign risingEdge = clkSync_r[1] & clkSync_r[2] & ~clkLevel_r;

  // ==========================================================
  // Capture
  // Upper half forced to zero for character words
  assign masked = wideMode ? laneData : {{(`LANE_W-`CHAR_W){1'b0}}, laneData[`CHAR_W-1:0]};

  // Data is sampled a few cycles after the lane edge, well inside its stable time
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strobe <= 1'b0;
      word   <= '0;
    end else begin
      strobe <= risingEdge & enable;
      if (risingEdge & enable) begin
        word <= masked;
      end
    end
  end

  AST_CAPTURE_MASK: assert property (@(posedge mclk) disable iff (rst)
    strobe |-> word == $past(masked)) else $error("captured word differs from masked lane");
endmodule
`default_nettype wire

// [logic/ctrl_decode.sv]
// Recovers control bits from green and red control characters and
// decides whether the link carries DVI or HDMI.
// Assumes the producer holds words steady between strobes.
`include "lane_input_consts.svh"
`default_nettype none
module ctrl_decode (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Captured lanes
  lane_if.consumer          lanes,
  // Results
  output logic [`CTRL_W-1:0] controlBits,
  output logic              hdmiMode
);
  logic [`SLOTS-1:0] preamble;

  // {valid, C1, C0} for one 10-bit symbol
  function automatic logic [2:0] decodeSym(input logic [`SYM_W-1:0] sym);
    unique case (sym)
      `CODE_CTL00: decodeSym = 3'h4;
      `CODE_CTL01: decodeSym = 3'h5;
      `CODE_CTL10: decodeSym = 3'h6;
      `CODE_CTL11: decodeSym = 3'h7;
      default:     decodeSym = 3'h0;
    endcase
  endfunction

  // ==========================================================
  // Per slot control bits
  genvar s;
  generate
    for (s = 0; s < `SLOTS; s++) begin : gSlot
      logic [2:0] grn;
      logic [2:0] red;
      assign grn = decodeSym(lanes.word[1][s*`SYM_W +: `SYM_W]);
      assign red = decodeSym(lanes.word[2][s*`SYM_W +: `SYM_W]);
      assign preamble[s] = grn[2] & red[2] & (|{grn[1:0], red[1:0]});
      // Updated on the lane-0 strobe; low two bits stay zero
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          controlBits[s*`FIELD_W +: `FIELD_W] <= '0;
        end else if (!lanes.locked) begin
          controlBits[s*`FIELD_W +: `FIELD_W] <= '0;
        end else if (lanes.strobe[0] && lanes.charMode && grn[2] && red[2]) begin
          controlBits[s*`FIELD_W +: `FIELD_W] <= {red[1], red[0], grn[1], grn[0], 2'h0};
        end
      end
      AST_CTRL_LOW_ZERO: assert property (@(posedge mclk) disable iff (rst)
        controlBits[s*`FIELD_W +: 2] == 2'h0) else $error("reserved control bits not zero");
    end
  endgenerate

  // ==========================================================
  // Link type: a preamble only occurs on HDMI; cleared when lock drops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hdmiMode <= 1'b0;
    end else if (!lanes.locked) begin
      hdmiMode <= 1'b0;
    end else if (lanes.strobe[0] && lanes.charMode && (|preamble)) begin
      hdmiMode <= 1'b1;
    end
  end

  AST_HDMI_ON_LANE0: assert property (@(posedge mclk) disable iff (rst)
    $rose(hdmiMode) |-> $past(lanes.strobe[0]) && $past(lanes.charMode)) else $error("link type moved off lane-0 strobe");
endmodule
`default_nettype wire

// [logic/tmds_frl_sink_lane_input.sv]
// Top of the sink lane input stage: bus slave, lane capture, lock and
// equaliser level synchronisers, control decoding.
// Assumes lane clocks, lock and equaliser level come from other domains
// and are sampled here; the bus runs on mclk.
`include "lane_input_consts.svh"
`default_nettype none
module tmds_frl_sink_lane_input (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst,
  // Register bus slave
  input  wire logic [`ADDR_W-1:0]           address,
  input  wire logic                         read,
  input  wire logic                         write,
  input  wire logic [31:0]                  writedata,
  input  wire logic [3:0]                   byteenable,
  output logic [31:0]                       readdata,
  output logic                              waitrequest,
  // Transceiver lanes
  input  wire logic [`NLANES-1:0]           link_lane_clock,
  input  wire logic [`LANE_W-1:0]           blueLaneIn,
  input  wire logic [`LANE_W-1:0]           greenLaneIn,
  input  wire logic [`LANE_W-1:0]           redLaneIn,
  input  wire logic [`LANE_W-1:0]           fourthLaneIn,
  input  wire logic                         transceiverLocked,
  // Management domain
  input  wire logic [3:0]                   ffeLevelIn,
  // Captured lanes towards the decoder
  output logic [`NLANES-1:0][`LANE_W-1:0]   laneWord,
  output logic [`NLANES-1:0]                laneStrobe,
  // Decoder status
  output logic [`CTRL_W-1:0]                controlBits,
  output logic                              hdmiMode
);
  logic [`ADDR_W-1:0]                ctrl_r;
  logic [2:0]                        lockSync_r;
  logic                              locked_r;
  logic [2:0][3:0]                   ffeSync_r;
  logic [3:0]                        ffeLevel_r;
  logic [`NLANES-1:0]                laneActive;
  logic [`NLANES-1:0][`LANE_W-1:0]   laneIn;
  logic                              frlMode;
  logic                              wideMode;
  logic [3:0]                        frlRate;
  logic [31:0]                       readMux;
  lane_input_pkg::busState_t         busState_r;
  lane_input_pkg::busState_t         busState_nxt;
  lane_if                            lanes ();

  // ==========================================================
  // Configuration fields
  assign frlMode  = ctrl_r[`CTRL_FRL];
  assign frlRate  = ctrl_r[`CTRL_RATE_MSB:`CTRL_RATE_LSB];
  // Wide words only when support is on and the link runs fixed-rate
  assign wideMode = frlMode & ctrl_r[`CTRL_SUPPORT];

  // ==========================================================
  // Lock synchroniser
  // Stage 0 feeds only stage 1
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lockSync_r <= 3'h0;
    end else begin
      lockSync_r <= {lockSync_r[1:0], transceiverLocked};
    end
  end

  // Lock moves once stages 1 and 2 agree
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      locked_r <= 1'b0;
    end else if (lockSync_r[1] == lockSync_r[2]) begin
      locked_r <= lockSync_r[2];
    end
  end

  // ==========================================================
  // Equaliser level synchroniser
  // The level changes seldom, so per-bit stages plus agreement suffice
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ffeSync_r <= '0;
    end else begin
      ffeSync_r <= {ffeSync_r[1], ffeSync_r[0], ffeLevelIn};
    end
  end

  // Whole word taken only when stages 1 and 2 agree
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ffeLevel_r <= 4'h0;
    end else if (ffeSync_r[1] == ffeSync_r[2]) begin
      ffeLevel_r <= ffeSync_r[2];
    end
  end

  // ==========================================================
  // Lane roles
  // Blue/lane 0, green/lane 1, red/lane 2, fourth/lane 3
  assign laneIn[0] = blueLaneIn;
  assign laneIn[1] = greenLaneIn;
  assign laneIn[2] = redLaneIn;
  assign laneIn[3] = fourthLaneIn;

  // Lanes 0..2 always carry data once locked
  assign laneActive[0] = locked_r;
  assign laneActive[1] = locked_r;
  assign laneActive[2] = locked_r;
  // Fourth lane: fixed-rate mode with support, and only at four-lane rates
  assign laneActive[3] = locked_r & wideMode & (frlRate >= `RATE_4LANE);

  // ==========================================================
  // Lane capture, one per lane on its own lane clock
  genvar l;
  generate
    for (l = 0; l < `NLANES; l++) begin : gLane
      lane_capture uCapture (
        .mclk      (mclk),
        .rst       (rst),
        .laneClock (link_lane_clock[l]),
        .laneData  (laneIn[l]),
        .enable    (laneActive[l]),
        .wideMode  (wideMode),
        .strobe    (laneStrobe[l]),
        .word      (laneWord[l])
      );
    end
  endgenerate

  // ==========================================================
  // Decoder
  assign lanes.word     = laneWord;
  assign lanes.strobe   = laneStrobe;
  assign lanes.charMode = ~frlMode;
  assign lanes.locked   = locked_r;

  ctrl_decode uDecode (
    .mclk        (mclk),
    .rst         (rst),
    .lanes       (lanes.consumer),
    .controlBits (controlBits),
    .hdmiMode    (hdmiMode)
  );

  // ==========================================================
  // Bus slave sequence
  // One wait cycle on every access keeps read data registered
  always_comb begin
    busState_nxt = busState_r;
    unique case (busState_r)
      lane_input_pkg::BUS_IDLE: begin
        if (read || write) begin
          busState_nxt = lane_input_pkg::BUS_ANSWER;
        end
      end
      lane_input_pkg::BUS_ANSWER: begin
        busState_nxt = lane_input_pkg::BUS_IDLE;
      end
      default: begin
        busState_nxt = lane_input_pkg::BUS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busState_r <= lane_input_pkg::BUS_IDLE;
    end else begin
      busState_r <= busState_nxt;
    end
  end

  assign waitrequest = (busState_r != lane_input_pkg::BUS_ANSWER);

  // Read selection; unmapped words read zero
  always_comb begin
    readMux = 32'h0;
    unique case (address)
      `REG_CTRL: begin
        readMux[`ADDR_W-1:0] = ctrl_r;
      end
      `REG_STATUS: begin
        readMux[`ST_LOCK]                       = locked_r;
        readMux[`ST_HDMI]                       = hdmiMode;
        readMux[`ST_LANE_LSB +: `NLANES]        = laneActive;
        readMux[`ST_CTRL_LSB +: `CTRL_W]        = controlBits;
      end
      `REG_SINKCFG: begin
        readMux[`FFE_LSB +: 4]                  = ffeLevel_r;
      end
      default: begin
        readMux = 32'h0;
      end
    endcase
  end

  // Read data loaded as the wait cycle ends, stands in the answer cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0;
    end else if (busState_r == lane_input_pkg::BUS_IDLE && read) begin
      readdata <= readMux;
    end
  end

  // Control register; only the low byte holds fields
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `CTRL_RESET;
    end else if (busState_r == lane_input_pkg::BUS_ANSWER && write &&
                 address == `REG_CTRL && byteenable[0]) begin
      ctrl_r <= writedata[`ADDR_W-1:0];
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_CHAR_UPPER_ZERO: assert property (
    laneStrobe[0] && !wideMode |-> laneWord[0][`LANE_W-1:`CHAR_W] == '0)
    else $error("character word carries upper bits");

  AST_FOURTH_IGNORED: assert property (
    !frlMode |-> ##1 !laneStrobe[3])
    else $error("fourth lane captured in character mode");

  AST_NO_DATA_UNLOCKED: assert property (
    !locked_r |-> ##1 laneStrobe == '0)
    else $error("lane data taken without lock");

  AST_LOW_RATE_THREE: assert property (
    frlMode && frlRate < `RATE_4LANE |-> ##1 !laneStrobe[3])
    else $error("fourth lane used at a three-lane rate");

  AST_FFE_READBACK: assert property (
    busState_r == lane_input_pkg::BUS_IDLE && read && address == `REG_SINKCFG
    |=> readdata[`FFE_LSB +: 4] == $past(ffeLevel_r) && !waitrequest)
    else $error("equaliser level not at bits 4 to 7");

  AST_ANSWER_ONE_WAIT: assert property (
    busState_r == lane_input_pkg::BUS_IDLE && (read || write) |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not after one wait cycle");

  AST_LANE0_ROLE: assert property (
    laneStrobe[0] && wideMode |-> laneWord[0] == $past(blueLaneIn))
    else $error("lane 0 word not from the first lane input");

  // One pulse per lane clock edge
  AST_STROBE_SINGLE: assert property (
    laneStrobe[0] |=> !laneStrobe[0])
    else $error("lane 0 strobe longer than one cycle");

  // Lock moves only once the late stages agree, so a glitch is ignored
  AST_LOCK_FILTERED: assert property (
    $changed(locked_r) |-> $past(lockSync_r[1]) == $past(lockSync_r[2]))
    else $error("lock moved before its stages agreed");

  // Status shows the filtered lock
  AST_STATUS_LOCK: assert property (
    busState_r == lane_input_pkg::BUS_IDLE && read && address == `REG_STATUS
    |=> readdata[`ST_LOCK] == $past(locked_r))
    else $error("status lock bit differs from lock");

  // Status shows the link type
  AST_STATUS_LINK_TYPE: assert property (
    busState_r == lane_input_pkg::BUS_IDLE && read && address == `REG_STATUS
    |=> readdata[`ST_HDMI] == $past(hdmiMode))
    else $error("status link type differs from output");

  // Link type only falls back to DVI on lock loss
  AST_LINK_TYPE_STICKY: assert property (
    $fell(hdmiMode) |-> !$past(locked_r))
    else $error("link type dropped while locked");

  // Control bits move only on a character-mode lane-0 word or lock loss
  AST_CTRL_BITS_HELD: assert property (
    $changed(controlBits) |-> ($past(laneStrobe[0]) && !$past(frlMode)) || !$past(locked_r))
    else $error("control bits moved without a lane-0 word");

  // Fourth lane only with wide words at a four-lane rate
  AST_LANE3_FOUR_LANE: assert property (
    laneStrobe[3] |-> $past(wideMode) && $past(frlRate) >= `RATE_4LANE)
    else $error("fourth lane captured outside four-lane mode");

  // Equaliser level moves only once its late stages agree
  AST_FFE_FILTERED: assert property (
    $changed(ffeLevel_r) |-> $past(ffeSync_r[1]) == $past(ffeSync_r[2]))
    else $error("equaliser level moved before its stages agreed");

  // Equaliser level takes the last stage
  AST_FFE_FOLLOWS: assert property (
    $changed(ffeLevel_r) |-> ffeLevel_r == $past(ffeSync_r[2]))
    else $error("equaliser level not from the last stage");

  // A control write lands at the answer edge
  AST_CTRL_WRITE_LANDS: assert property (
    busState_r == lane_input_pkg::BUS_ANSWER && write && address == `REG_CTRL && byteenable[0]
    |=> ctrl_r == $past(writedata[`ADDR_W-1:0]))
    else $error("control write did not land");

  // Bus sequence stays on a legal one-hot code
  AST_BUS_STATE_LEGAL: assert property (
    busState_r == lane_input_pkg::BUS_IDLE || busState_r == lane_input_pkg::BUS_ANSWER)
    else $error("bus sequence left its legal codes");
endmodule
`default_nettype wire

// [verification/lane_phy_model.sv]
// Behavioural transceiver: recovered lane clocks and lane data for four lanes.
// Assumes the bench calls sendFrame from a procedural block, one frame at a time.
`include "lane_input_consts.svh"
`default_nettype none
module lane_phy_model (
  // Lanes towards the sink
  output logic [`NLANES-1:0]              laneClk,
  output logic [`NLANES-1:0][`LANE_W-1:0] laneData
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Idle state: clocks stand still outside frames
  initial begin
    laneClk  = '0;
    laneData = '0;
  end

  // ==========================================================
  // One 80 ns lane clock period carries one word per lane
  task automatic sendFrame(input logic [`NLANES-1:0][`LANE_W-1:0] w, input int gap);
    #3;
    laneData = w;
    laneClk  = '1;
    #40;
    laneClk = '0;
    #40;
    // Released lines carry the inverse so a stale word never looks valid
    laneData = ~w;
    #(gap);
  endtask
endmodule
`default_nettype wire

// [verification/tmds_frl_sink_lane_input_tb.sv]
// Self-checking bench for the sink lane input stage: register bus, lane capture
// in both modes, control decoding, link type and equaliser level.
// Assumes the transceiver model lane_phy_model and the design constants header.
`include "lane_input_consts.svh"
`default_nettype none
module tmds_frl_sink_lane_input_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Signals and reference state
  logic                            mclk = 1'b0;
  logic                            rst = 1'b1;
  logic [`ADDR_W-1:0]              address = '0;
  logic                            read = 1'b0;
  logic                            write = 1'b0;
  logic [31:0]                     writedata = '0;
  logic [31:0]                     readdata;
  logic                            waitrequest;
  logic [`NLANES-1:0]              laneClk;
  logic [`NLANES-1:0][`LANE_W-1:0] laneData;
  logic                            locked = 1'b0;
  logic [3:0]                      ffeLevel = 4'h0;
  logic [`NLANES-1:0][`LANE_W-1:0] laneWord;
  logic [`NLANES-1:0]              laneStrobe;
  logic [`CTRL_W-1:0]              controlBits;
  logic                            hdmiMode;
  logic [31:0]                     seed = 32'hf99d114c;
  logic [9:0]                      codes [4] = '{`CODE_CTL00, `CODE_CTL01, `CODE_CTL10, `CODE_CTL11};
  logic [5:0]                      cfgs [6] = '{6'h0d, 6'h07, 6'h0b, 6'h0f, 6'h1b, 6'h0e};
  int                              badCount = 0;
  int                              totalChecks = 0;
  int                              seen [4];
  logic [`LANE_W-1:0]              got [4];
  logic [`CTRL_W-1:0]              ctrlExp = '0;
  logic                            hdmiExp = 1'b0;
  logic [5:0]                      cfg = '0;

  // ==========================================================
  // Design and transceiver model
  tmds_frl_sink_lane_input dut (
    .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
    .link_lane_clock(laneClk), .blueLaneIn(laneData[0]), .greenLaneIn(laneData[1]),
    .redLaneIn(laneData[2]), .fourthLaneIn(laneData[3]), .transceiverLocked(locked),
    .ffeLevelIn(ffeLevel), .laneWord(laneWord), .laneStrobe(laneStrobe),
    .controlBits(controlBits), .hdmiMode(hdmiMode)
  );
  lane_phy_model phy (.laneClk(laneClk), .laneData(laneData));

  // System clock, 100 MHz
  always #5 mclk = ~mclk;

  // Count lane strobes and keep the word each one carried
  always @(posedge mclk) begin
    for (int l = 0; l < 4; l++) begin
      if (laneStrobe[l] === 1'b1) begin
        seen[l]++;
        got[l] = laneWord[l];
      end
    end
  end

  // ==========================================================
  // Helpers
  task automatic closeOut();
    if (badCount == 0 && totalChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [39:0] g, input logic [39:0] e, input string m);
    totalChecks++;
    if (g !== e) begin
      badCount++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [`NLANES-1:0][`LANE_W-1:0] rnd();
    logic [`NLANES-1:0][`LANE_W-1:0] r;
    for (int l = 0; l < 4; l++) r[l] = 40'({xs(), xs()});
    return r;
  endfunction

  // Bus master: hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge mclk);
    address   <= a;
    read      <= !wr;
    write     <= wr;
    writedata <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    chk(n, 2, "bus answer cycles");
  endtask

  task automatic regCheck(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, '0, q);
    chk(q & m, e, "register read");
  endtask

  // Send one word twice per lane, back to back, then stall for a random time
  task automatic frame(input logic [`NLANES-1:0][`LANE_W-1:0] w);
    logic [`LANE_W-1:0] e;
    int                 gIdx;
    int                 rIdx;
    foreach (seen[l]) seen[l] = 0;
    phy.sendFrame(w, 0);
    phy.sendFrame(w, 10 * (xs() % 8));
    repeat (2) @(posedge mclk);
    for (int l = 0; l < 4; l++) begin
      e = (cfg[0] && cfg[1]) ? w[l] : {20'h0, w[l][19:0]};
      if (locked && (l < 3 || (cfg[0] && cfg[1] && cfg[5:2] >= `RATE_4LANE))) begin
        chk(seen[l], 2, "strobe count");
        chk(got[l], e, "lane word");
      end else begin
        chk(seen[l], 0, "ignored lane");
      end
    end
    // Both channels must hold control characters for a slot to update
    if (locked && !cfg[0]) begin
      for (int s = 0; s < 2; s++) begin
        gIdx = -1;
        rIdx = -1;
        for (int k = 0; k < 4; k++) begin
          if (w[1][s*10+:10] == codes[k]) gIdx = k;
          if (w[2][s*10+:10] == codes[k]) rIdx = k;
        end
        if (gIdx >= 0 && rIdx >= 0) ctrlExp[s*6+:6] = {rIdx[1:0], gIdx[1:0], 2'b00};
      end
      hdmiExp = hdmiExp | (ctrlExp != '0);
    end
    chk(controlBits, ctrlExp, "control bits");
    chk(hdmiMode, hdmiExp, "link type");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0]                     q;
    logic [`NLANES-1:0][`LANE_W-1:0] w;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    chk(waitrequest, 1'b1, "idle bus");
    chk(laneStrobe, 4'h0, "strobe at reset");
    regCheck(`REG_CTRL, 32'hffffffff, 32'h0);
    regCheck(6'h2a, 32'hffffffff, 32'h0);
    bus(1'b1, 6'h2a, xs(), q);
    // Equaliser level crosses from the management domain; writes are ignored
    for (int i = 0; i < 3; i++) begin
      ffeLevel <= 4'(xs());
      repeat (6) @(posedge mclk);
      bus(1'b1, `REG_SINKCFG, xs(), q);
      regCheck(`REG_SINKCFG, 32'hffffffff, {24'h0, ffeLevel, 4'h0});
    end
    frame(rnd());
    locked <= 1'b1;
    repeat (8) @(posedge mclk);
    // Blank control period first, so the link still reads as DVI
    w = rnd();
    w[1][19:0] = {codes[0], codes[0]};
    w[2][19:0] = {codes[0], codes[0]};
    frame(w);
    for (int i = 0; i < 10; i++) begin
      w = rnd();
      w[1][19:0] = {codes[xs() % 4], codes[xs() % 4]};
      w[2][19:0] = {codes[xs() % 4], codes[xs() % 4]};
      if (i == 9) w[1][19:10] = 10'h000;
      frame(w);
    end
    regCheck(`REG_STATUS, 32'h000ffff3, {12'h0, ctrlExp, 4'h7, 2'h0, hdmiExp, 1'b1});
    // Every mode and lane count, control bits held outside character mode
    foreach (cfgs[i]) begin
      cfg = cfgs[i];
      bus(1'b1, `REG_CTRL, {26'h0, cfg}, q);
      regCheck(`REG_CTRL, 32'h3f, {26'h0, cfg});
      frame(rnd());
    end
    locked  <= 1'b0;
    hdmiExp = 1'b0;
    repeat (8) @(posedge mclk);
    chk(hdmiMode, 1'b0, "link type after lock loss");
    chk(controlBits, 12'h0, "control bits after lock loss");
    regCheck(`REG_STATUS, 32'h3, 32'h0);
    closeOut();
  end

  // Watchdog, far beyond the expected run of about five hundred cycles
  initial begin
    #100000;
    badCount++;
    closeOut();
  end
endmodule
`default_nettype wire
